// ### aecc_ctrl.sv
/*
 * Control, status and counting logic of a two-channel event counter pair.
 * Assumes: pins are asynchronous and synchronised here; the gating PWM
 * waveform comes from a PWM generator on the same clock.
 */
// Overview of operation
// - Low pin edge field: 00 falling, 01 rising, 10 both, 11 prohibited.
// - Gate pin edge field: 00 falling, 01 rising, 10 both, 11 prohibited.
// - PWM enable 0 halts PWM and uses gate pin; 1 runs PWM.
// - Bit 0 of edge and clock registers is reserved read/write, reset 0.
// - High counter clock: pin, clock/2, clock/4 or clock/8.
// - Low counter clock: pin, clock/2, clock/4 or clock/8.
// - Gating PWM clock divides by 2,4,8,16,32 or 64.
// - Control/status register clears fully on reset.
// - High overflow flag sets on high counter wrap; writes cannot set it.
// - High flag clears only by writing 0 after reading it as 1.
// - In chained mode high flag marks the 16-bit wrap.
// - Low overflow flag sets on low counter wrap; writes cannot set it.
// - Low flag clears only by writing 0 after reading it as 1.
// - Writes of 1 to either flag bit are ignored.
// - Control bit 5 is reserved read/write, stores value, resets 0.
// - Split select 0 chains counters; low wrap clocks the high counter.
// - Split select 1 runs two independent 8-bit counters.
// - Counters advance only while gate pin or PWM output is high.
// - Count enable 0 holds a counter; 1 lets events increment it.
// - Reset release 0 holds counter at zero; 1 allows counting.
`timescale 1ns/1ns
`default_nettype none

module aecc_ctrl (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire aecc_pkg::aecc_wb_req_t wb_req_i,
	output var aecc_pkg::aecc_wb_rsp_t  wb_rsp_o,
	input  wire logic                   high_event_pin_i,
	input  wire logic                   low_event_pin_i,
	input  wire logic                   count_gate_pin_i,
	input  wire logic                   gating_pwm_output_i,
	output logic                        pwm_run_o,
	output logic                        pwm_clk_en_o,
	output logic                        gate_edge_o
);
	import aecc_pkg::*;

	typedef struct packed {
		logic [7:0]  edge_sel;
		logic [7:0]  clk_sel;
		logic [5:0]  ctl;
		logic        high_ovf;
		logic        low_ovf;
		logic        high_armed;
		logic        low_armed;
		logic [7:0]  upper_cnt;
		logic [7:0]  lower_cnt;
		logic [5:0]  prescale;
		logic [2:0]  high_pin_s;
		logic [2:0]  low_pin_s;
		logic [2:0]  gate_pin_s;
		logic        ack;
		logic [31:0] rdata;
		logic        pwm_tick;
		logic        gate_edge;
	} aecc_state_t;

	aecc_state_t s;
	aecc_state_t next_s;

	// Edge match on synchronised level and its previous value
	function automatic logic edge_hit(input logic [1:0] code, input logic cur, input logic prev);
		unique case (aecc_edge_t'(code))
			EDGE_FALL: edge_hit = prev & ~cur;
			EDGE_RISE: edge_hit = ~prev & cur;
			EDGE_BOTH: edge_hit = prev ^ cur;
			EDGE_NONE: edge_hit = 1'b0;
		endcase
	endfunction

	// One-cycle pulse every 2**k cycles
	function automatic logic tick(input logic [5:0] pre, input logic [2:0] k);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (3'(i) < k) begin
				hit = hit & pre[i];
			end
		end
		tick = hit;
	endfunction

	function automatic logic src_event(input logic [1:0] sel, input logic pin_edge,
		input logic [5:0] pre);
		unique case (aecc_src_t'(sel))
			SRC_PIN:  src_event = pin_edge;
			SRC_DIV2: src_event = tick(pre, 3'd1);
			SRC_DIV4: src_event = tick(pre, 3'd2);
			SRC_DIV8: src_event = tick(pre, 3'd3);
		endcase
	endfunction

	logic       access;
	logic       wr_en;
	logic [7:0] wdat;
	logic       gate_open;
	logic       low_evt;
	logic       low_wrap;
	logic       high_evt;
	logic       high_wrap;
	logic       clear_high;
	logic       clear_low;
	logic       rd_ctl;
	logic [2:0] pwm_div;
	logic [7:0] ctl_view;

	always_comb begin
		next_s = s;

		// Two-stage synchronisers, third stage for edge history
		next_s.high_pin_s = {s.high_pin_s[1:0], high_event_pin_i};
		next_s.low_pin_s  = {s.low_pin_s[1:0], low_event_pin_i};
		next_s.gate_pin_s = {s.gate_pin_s[1:0], count_gate_pin_i};
		next_s.prescale   = s.prescale + 6'h01;

		// enable bit swaps gate pin for PWM
		gate_open = s.edge_sel[PWM_ENABLE_POS] ? gating_pwm_output_i : s.gate_pin_s[1];

		next_s.gate_edge = edge_hit(s.edge_sel[GATE_PIN_EDGE_POS +: 2],
			s.gate_pin_s[1], s.gate_pin_s[2]);

		unique casez (s.clk_sel[PWM_CLK_SEL_POS +: 3])
			3'b000: pwm_div = 3'd1;
			3'b001: pwm_div = 3'd2;
			3'b010: pwm_div = 3'd3;
			3'b011: pwm_div = 3'd4;
			3'b1?0: pwm_div = 3'd5;
			default: pwm_div = 3'd6;
		endcase
		next_s.pwm_tick = s.edge_sel[PWM_ENABLE_POS] & tick(s.prescale, pwm_div);

		low_evt = gate_open & s.ctl[LOW_CNT_EN_POS] & s.ctl[LOW_RST_REL_POS]
			& src_event(s.clk_sel[LOW_CLK_SEL_POS +: 2],
				edge_hit(s.edge_sel[LOW_PIN_EDGE_POS +: 2], s.low_pin_s[1], s.low_pin_s[2]),
				s.prescale);
		low_wrap = low_evt & (s.lower_cnt == COUNT_ALL_ONES);

		if (s.ctl[SPLIT_SEL_POS]) begin
			high_evt = gate_open & src_event(s.clk_sel[HIGH_CLK_SEL_POS +: 2],
				edge_hit(s.edge_sel[HIGH_PIN_EDGE_POS +: 2], s.high_pin_s[1],
					s.high_pin_s[2]), s.prescale);
		end else begin
			high_evt = low_wrap;
		end
		high_evt  = high_evt & s.ctl[HIGH_CNT_EN_POS] & s.ctl[HIGH_RST_REL_POS];
		high_wrap = high_evt & (s.upper_cnt == COUNT_ALL_ONES);

		// reset release holds counters at zero
		if (!s.ctl[LOW_RST_REL_POS]) begin
			next_s.lower_cnt = RST_COUNT;
		end else if (low_evt) begin
			next_s.lower_cnt = s.lower_cnt + 8'h01;
		end
		if (!s.ctl[HIGH_RST_REL_POS]) begin
			next_s.upper_cnt = RST_COUNT;
		end else if (high_evt) begin
			next_s.upper_cnt = s.upper_cnt + 8'h01;
		end

		// Bus: one wait state, ack dropped after one cycle
		access = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
		wr_en  = access & wb_req_i.we & wb_req_i.sel[0];
		wdat   = wb_req_i.dat[7:0];
		rd_ctl = access & ~wb_req_i.we & (wb_req_i.adr == OFS_CTL_STAT);
		next_s.ack   = access;
		next_s.rdata = 32'h0000_0000;

		ctl_view = {s.high_ovf, s.low_ovf, s.ctl};
		if (access && !wb_req_i.we) begin
			unique case (wb_req_i.adr)
				OFS_EDGE_SEL:  next_s.rdata = {24'h00_0000, s.edge_sel};
				OFS_CLK_SEL:   next_s.rdata = {24'h00_0000, s.clk_sel};
				OFS_CTL_STAT:  next_s.rdata = {24'h00_0000, ctl_view};
				OFS_UPPER_CNT: next_s.rdata = {24'h00_0000, s.upper_cnt};
				OFS_LOWER_CNT: next_s.rdata = {24'h00_0000, s.lower_cnt};
				default:       next_s.rdata = 32'h0000_0000;
			endcase
		end

		// reserved bit 0 stored as written
		if (wr_en && wb_req_i.adr == OFS_EDGE_SEL) begin
			next_s.edge_sel = wdat;
		end
		if (wr_en && wb_req_i.adr == OFS_CLK_SEL) begin
			next_s.clk_sel = wdat;
		end
		// bit 5 stored with the controls
		if (wr_en && wb_req_i.adr == OFS_CTL_STAT) begin
			next_s.ctl = wdat[5:0];
		end

		// only a written 0 can clear
		clear_high = wr_en && wb_req_i.adr == OFS_CTL_STAT && !wdat[HIGH_OVF_POS] && s.high_armed;
		clear_low  = wr_en && wb_req_i.adr == OFS_CTL_STAT && !wdat[LOW_OVF_POS] && s.low_armed;

		next_s.high_ovf = high_wrap | (s.high_ovf & ~clear_high);
		next_s.low_ovf  = low_wrap | (s.low_ovf & ~clear_low);

		// record reads of a set flag
		if (high_wrap || clear_high) begin
			next_s.high_armed = 1'b0;
		end else if (rd_ctl && s.high_ovf) begin
			next_s.high_armed = 1'b1;
		end
		if (low_wrap || clear_low) begin
			next_s.low_armed = 1'b0;
		end else if (rd_ctl && s.low_ovf) begin
			next_s.low_armed = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s            <= '0;
			s.edge_sel   <= RST_EDGE_SEL;
			s.clk_sel    <= RST_CLK_SEL;
			s.ctl        <= RST_CTL_STAT[5:0];
			s.high_ovf   <= RST_CTL_STAT[HIGH_OVF_POS];
			s.low_ovf    <= RST_CTL_STAT[LOW_OVF_POS];
			s.upper_cnt  <= RST_COUNT;
			s.lower_cnt  <= RST_COUNT;
		end else begin
			s <= next_s;
		end
	end

	assign wb_rsp_o.ack = s.ack;
	assign wb_rsp_o.dat = s.rdata;
	assign pwm_run_o    = s.edge_sel[PWM_ENABLE_POS];
	assign pwm_clk_en_o = s.pwm_tick;
	assign gate_edge_o  = s.gate_edge;

endmodule

`default_nettype wire

// ### aecc_pkg.sv
/*
 * Shared constants and carrier types for the event counter control block.
 * Assumes a classic Wishbone master with 32-bit data and byte addressing.
 */
`default_nettype none

package aecc_pkg;

	// Register byte offsets, one 32-bit word each
	localparam logic [7:0] OFS_EDGE_SEL  = 8'h00;
	localparam logic [7:0] OFS_CLK_SEL   = 8'h04;
	localparam logic [7:0] OFS_CTL_STAT  = 8'h08;
	localparam logic [7:0] OFS_UPPER_CNT = 8'h0C;
	localparam logic [7:0] OFS_LOWER_CNT = 8'h10;

	// Reset values
	localparam logic [7:0] RST_EDGE_SEL = 8'h00;
	localparam logic [7:0] RST_CLK_SEL  = 8'h00;
	localparam logic [7:0] RST_CTL_STAT = 8'h00;
	localparam logic [7:0] RST_COUNT    = 8'h00;

	// Edge select register fields
	localparam int HIGH_PIN_EDGE_POS = 6;
	localparam int LOW_PIN_EDGE_POS  = 4;
	localparam int GATE_PIN_EDGE_POS = 2;
	localparam int PWM_ENABLE_POS    = 1;

	// Clock select register fields
	localparam int HIGH_CLK_SEL_POS  = 6;
	localparam int LOW_CLK_SEL_POS   = 4;
	localparam int PWM_CLK_SEL_POS   = 1;

	// Control/status register fields
	localparam int HIGH_OVF_POS      = 7;
	localparam int LOW_OVF_POS       = 6;
	localparam int SPLIT_SEL_POS     = 4;
	localparam int HIGH_CNT_EN_POS   = 3;
	localparam int LOW_CNT_EN_POS    = 2;
	localparam int HIGH_RST_REL_POS  = 1;
	localparam int LOW_RST_REL_POS   = 0;

	localparam logic [7:0] COUNT_ALL_ONES = 8'hFF;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BOTH = 2'b10,
		EDGE_NONE = 2'b11
	} aecc_edge_t;

	typedef enum logic [1:0] {
		SRC_PIN  = 2'b00,
		SRC_DIV2 = 2'b01,
		SRC_DIV4 = 2'b10,
		SRC_DIV8 = 2'b11
	} aecc_src_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} aecc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} aecc_wb_rsp_t;

endpackage

`default_nettype wire

// ### aecc_ctrl_properties.sv
/* Bus and output checks for the event counter control block.
 Assumes it is bound onto aecc_ctrl. */
`timescale 1ns/1ns
`default_nettype none
module aecc_ctrl_properties (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire aecc_pkg::aecc_wb_req_t wb_req_i,
	input wire aecc_pkg::aecc_wb_rsp_t wb_rsp_o,
	input wire logic                   pwm_run_o,
	input wire logic                   pwm_clk_en_o,
	input wire logic                   gate_edge_o
);
	import aecc_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	endsequence
	sequence s_edge_wr;
		s_take ##0 (wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == OFS_EDGE_SEL);
	endsequence
	a_ack_one_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack longer than one cycle");
	a_take_acked: assert property (s_take |=> wb_rsp_o.ack)
		else $error("request not acked");
	a_idle_dat_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0000_0000)
		else $error("read data outside ack");
	a_upper_dat_zero: assert property (wb_rsp_o.dat[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_pwm_run_set: assert property (s_edge_wr |=> ##1
		pwm_run_o == $past(wb_req_i.dat[PWM_ENABLE_POS], 2)) else $error("pwm run wrong");
	a_pwm_clk_gated: assert property (!pwm_run_o && !$past(pwm_run_o) |-> !pwm_clk_en_o)
		else $error("pwm clock while halted");
	a_pwm_tick_pulse: assert property (pwm_clk_en_o |=> !pwm_clk_en_o)
		else $error("pwm tick too long");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
		!wb_rsp_o.ack && !pwm_run_o && !pwm_clk_en_o && !gate_edge_o)
		else $error("outputs active after reset");
endmodule
bind aecc_ctrl aecc_ctrl_properties i_aecc_ctrl_properties (.clk_i(clk_i), .rst_i(rst_i),
	.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pwm_run_o(pwm_run_o),
	.pwm_clk_en_o(pwm_clk_en_o), .gate_edge_o(gate_edge_o));
`default_nettype wire

// ### test_aecc_ctrl.sv
/* Self-checking bench for the event counter control block.
 Assumes the checker is bound onto the design. */
`timescale 1ns/1ns
`default_nettype none
module test_aecc_ctrl;
	import aecc_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	aecc_wb_req_t req   = '0;
	aecc_wb_rsp_t rsp;
	logic         hi_pin = 1'b0, lo_pin = 1'b0, gate = 1'b1, pwm = 1'b0;
	logic         pwm_run, pwm_clk, gate_edge;
	logic [31:0]  exp_q[$];
	int           seed = 94, fails = 0, total_checks = 0, n_pwm = 0, n_gate = 0, i, s;
	aecc_ctrl i_aecc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
		.high_event_pin_i(hi_pin), .low_event_pin_i(lo_pin), .count_gate_pin_i(gate),
		.gating_pwm_output_i(pwm), .pwm_run_o(pwm_run), .pwm_clk_en_o(pwm_clk),
		.gate_edge_o(gate_edge));
	initial forever #25 clk_i = ~clk_i;
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want) begin
			fails++;
			$display("MISMATCH %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic results;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Writes expect zero data with their ack
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d,
		input logic [31:0] want);
		int n;
		n = 0;
		exp_q.push_back(want);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: d};
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp.ack !== 1'b1 && n < 20);
		if (rsp.ack !== 1'b1) begin
			fails++;
			results;
		end
		req <= '0;
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (rsp.ack === 1'b1)
			check(rsp.dat, exp_q.pop_front());
		if (gate_edge === 1'b1)
			n_gate++;
		if (pwm_clk === 1'b1)
			n_pwm++;
		hi_pin <= $random(seed);
		lo_pin <= $random(seed);
		pwm    <= $random(seed);
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 5; i++)
			bus(1'b0, 8'(4 * i), '0, '0);
		// Prohibited edge code 11 never written
		for (i = 0; i < 3; i++) begin
			s = $random(seed);
			s = {i[1:0], i[1:0], i[1:0], s[1], 1'b0};
			bus(1'b1, OFS_EDGE_SEL, s, '0);
			bus(1'b0, OFS_EDGE_SEL, '0, s);
			s = $random(seed) & 32'h0000_00FE;
			bus(1'b1, OFS_CLK_SEL, s, '0);
			bus(1'b0, OFS_CLK_SEL, '0, s);
		end
		bus(1'b1, 8'h14, 32'h0000_00FF, '0);
		bus(1'b0, 8'h14, '0, '0);
		bus(1'b1, OFS_CTL_STAT, 32'h0000_00F0, '0);
		bus(1'b0, OFS_CTL_STAT, '0, 32'h0000_0030);
		$display("register test done");
		bus(1'b1, OFS_EDGE_SEL, 32'h0000_0002, '0);
		check(pwm_run, 32'h0000_0001);
		for (i = 0; i < 8; i++) begin
			bus(1'b1, OFS_CLK_SEL, i << 1, '0);
			@(negedge clk_i);
			s = n_pwm;
			repeat (128) @(negedge clk_i);
			check(n_pwm - s, 128 >> (i < 4 ? i + 1 : 5 + i[0]));
			@(posedge clk_i);
		end
		$display("pwm clock test done");
		for (i = 0; i < 3; i++) begin
			bus(1'b1, OFS_EDGE_SEL, i << 2, '0);
			s = n_gate;
			gate <= 1'b0;
			repeat (8) @(posedge clk_i);
			gate <= 1'b1;
			repeat (8) @(negedge clk_i);
			check(n_gate - s, i == 2 ? 2 : 1);
			@(posedge clk_i);
		end
		check(pwm_run, 32'h0000_0000);
		$display("gate edge test done");
		gate <= 1'b0;
		bus(1'b1, OFS_CLK_SEL, 32'h0000_0010, '0);
		bus(1'b1, OFS_CTL_STAT, 32'h0000_0015, '0);
		repeat (40) @(posedge clk_i);
		bus(1'b0, OFS_LOWER_CNT, '0, '0);
		gate <= 1'b1;
		repeat (600) @(posedge clk_i);
		bus(1'b1, OFS_CTL_STAT, 32'h0000_0015, '0);
		bus(1'b0, OFS_CTL_STAT, '0, 32'h0000_0055);
		bus(1'b1, OFS_CTL_STAT, 32'h0000_0015, '0);
		bus(1'b0, OFS_CTL_STAT, '0, 32'h0000_0015);
		$display("overflow flag test done");
		bus(1'b1, OFS_CTL_STAT, '0, '0);
		bus(1'b1, OFS_CTL_STAT, 32'h0000_000F, '0);
		repeat (600) @(posedge clk_i);
		bus(1'b0, OFS_UPPER_CNT, '0, 32'h0000_0001);
		bus(1'b1, OFS_CTL_STAT, 32'h0000_000C, '0);
		bus(1'b0, OFS_LOWER_CNT, '0, '0);
		$display("chained count test done");
		results;
	end
endmodule
`default_nettype wire
